// file: trigger_and_status_led.sv
// trigger qualification, address restore and status led control
// assumes one 25 MHz clock, synchronous reset, pins asynchronous
`timescale 1ns/1ps
`include "trigger_consts.svh"
module trigger_and_status_led #(
  parameter int unsigned PULSE_MIN_CYC  = `PULSE_MIN_CYC,
  parameter int unsigned PERIOD_MIN_CYC = `PERIOD_MIN_CYC,
  parameter int unsigned HOLD_LONG_CYC  = `HOLD_LONG_CYC,
  parameter int unsigned HOLD_SHORT_CYC = `HOLD_SHORT_CYC,
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        strobe_in_i,
  input  wire logic        net_address_restore_in_i,
  input  wire logic        restore_button_i,
  input  wire logic        slave_mode_i,
  input  wire logic [1:0]  range_mode_i,
  input  wire logic [23:0] exposure_cyc_0_i,
  input  wire logic [23:0] exposure_cyc_1_i,
  input  wire logic [23:0] exposure_cyc_2_i,
  input  wire logic [23:0] exposure_cyc_3_i,
  input  wire logic        host_connected_i,
  input  wire logic        fw_upgrade_i,
  input  wire logic        drv_upgrade_i,
  input  wire logic        gp_out_level_i,
  output logic             frame_start_o,
  output logic             exposure_window_o,
  output logic             net_addr_restore_o,
  output logic [31:0]      net_addr_default_o,
  output logic             self_reset_o,
  output trigger_pkg::led_rgb_s led_o,
  output logic             gp_out_o
);
  logic strobe_s;
  logic addr_pin_s;
  logic button_s;
  logic blink_phase;
  logic blink_edge;
  // pins cross into clk_i domain before anything looks at them
  level_sync u_sync_strobe (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (strobe_in_i),
    .level_o (strobe_s)
  );
  level_sync u_sync_addr (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (net_address_restore_in_i),
    .level_o (addr_pin_s)
  );
  level_sync u_sync_button (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   (restore_button_i),
    .level_o (button_s)
  );
  blink_divider #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .phase_o (blink_phase),
    .edge_o  (blink_edge)
  );
  // trigger qualification
  logic        strobe_prev_q;
  logic        strobe_prev_d;
  logic        armed_q;
  logic        armed_d;
  logic [19:0] width_q;
  logic [19:0] width_d;
  logic [20:0] since_q;
  logic [20:0] since_d;
  logic        period_ok_q;
  logic        period_ok_d;
  logic        start_q;
  logic        start_d;
  logic [23:0] expo_q;
  logic [23:0] expo_d;
  logic        expo_on_q;
  logic        expo_on_d;
  logic [23:0] expo_len;
  always_comb begin
    case (range_mode_i)
      2'h0:    expo_len = exposure_cyc_0_i;
      2'h1:    expo_len = exposure_cyc_1_i;
      2'h2:    expo_len = exposure_cyc_2_i;
      default: expo_len = exposure_cyc_3_i;
    endcase
  end
  always_comb begin
    strobe_prev_d = strobe_s;
    armed_d       = armed_q;
    width_d       = width_q;
    since_d       = since_q;
    period_ok_d   = period_ok_q;
    start_d       = 1'b0;
    expo_d        = expo_q;
    expo_on_d     = expo_on_q;
    if (since_q < 21'(PERIOD_MIN_CYC)) begin
      since_d = since_q + 21'h000001;
    end else begin
      period_ok_d = 1'b1;
    end
    // edge only counts when slave mode and period allow it
    if (!slave_mode_i) begin
      armed_d = 1'b0;
    end else if (strobe_s && !strobe_prev_q && period_ok_q) begin
      armed_d = 1'b1;
      width_d = 20'h00000;
    end else if (armed_q) begin
      if (!strobe_s) begin
        armed_d = 1'b0;
      end else if (width_q >= 20'(PULSE_MIN_CYC - 1)) begin
        // qualified once minimum width is seen, one start per edge
        armed_d     = 1'b0;
        start_d     = 1'b1;
        since_d     = 21'h000000;
        period_ok_d = 1'b0;
      end else begin
        width_d = width_q + 20'h00001;
      end
    end
    if (start_q) begin
      expo_d    = expo_len;
      expo_on_d = expo_len != 24'h000000;
    end else if (expo_on_q) begin
      if (expo_q <= 24'h000001) begin
        expo_on_d = 1'b0;
      end
      expo_d = expo_q - 24'h000001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strobe_prev_q <= 1'b0;
      armed_q       <= 1'b0;
      width_q       <= 20'h00000;
      since_q       <= 21'h000000;
      period_ok_q   <= 1'b0;
      start_q       <= 1'b0;
      expo_q        <= 24'h000000;
      expo_on_q     <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      armed_q       <= armed_d;
      width_q       <= width_d;
      since_q       <= since_d;
      period_ok_q   <= period_ok_d;
      start_q       <= start_d;
      expo_q        <= expo_d;
      expo_on_q     <= expo_on_d;
    end
  end
  // address restore and led state
  trigger_pkg::led_show_e show_q;
  trigger_pkg::led_show_e show_d;
  logic [27:0] pin_hold_q;
  logic [27:0] pin_hold_d;
  logic [27:0] btn_hold_q;
  logic [27:0] btn_hold_d;
  logic        pin_done_q;
  logic        pin_done_d;
  logic        btn_done_q;
  logic        btn_done_d;
  logic [1:0]  blinks_q;
  logic [1:0]  blinks_d;
  logic        restore_q;
  logic        restore_d;
  logic        self_reset_q;
  logic        self_reset_d;
  trigger_pkg::led_rgb_s led_q;
  trigger_pkg::led_rgb_s led_d;
  logic        gp_q;
  logic        gp_d;
  always_comb begin
    pin_hold_d   = pin_hold_q;
    btn_hold_d   = btn_hold_q;
    pin_done_d   = pin_done_q;
    btn_done_d   = btn_done_q;
    blinks_d     = blinks_q;
    restore_d    = 1'b0;
    self_reset_d = 1'b0;
    show_d       = show_q;
    gp_d         = gp_out_level_i;
    // pin: one restore per continuous 10 s high
    if (!addr_pin_s) begin
      pin_hold_d = 28'h0000000;
      pin_done_d = 1'b0;
    end else if (!pin_done_q) begin
      if (pin_hold_q >= 28'(HOLD_LONG_CYC - 1)) begin
        restore_d  = 1'b1;
        pin_done_d = 1'b1;
      end else begin
        pin_hold_d = pin_hold_q + 28'h0000001;
      end
    end
    // button: purple from 5 s, off and restore at 10 s
    if (!button_s) begin
      btn_hold_d = 28'h0000000;
      btn_done_d = 1'b0;
      if (show_q == trigger_pkg::SHOW_RESET_HOLD) begin
        show_d   = trigger_pkg::SHOW_RESET_BLINK;
        blinks_d = 2'h0;
      end
    end else if (!btn_done_q) begin
      if (btn_hold_q >= 28'(HOLD_LONG_CYC - 1)) begin
        restore_d  = 1'b1;
        btn_done_d = 1'b1;
        show_d     = trigger_pkg::SHOW_OFF;
      end else begin
        btn_hold_d = btn_hold_q + 28'h0000001;
        if (btn_hold_q == 28'(HOLD_SHORT_CYC - 1)) begin
          show_d = trigger_pkg::SHOW_RESET_HOLD;
        end
      end
    end
    case (show_q)
      trigger_pkg::SHOW_RESET_HOLD: begin
      end
      trigger_pkg::SHOW_RESET_BLINK: begin
        // two full blinks counted on falling blink phase
        if (blink_edge && !blink_phase) begin
          blinks_d = blinks_q + 2'h1;
          if (blinks_q == 2'h1) begin
            self_reset_d = 1'b1;
            restore_d    = 1'b1;
            show_d       = trigger_pkg::SHOW_BROADCAST;
          end
        end
      end
      trigger_pkg::SHOW_OFF: begin
        if (!button_s) begin
          show_d = trigger_pkg::SHOW_BROADCAST;
        end
      end
      default: begin
        // upgrades outrank link state; a fresh reset hold outranks both
        if (show_d != show_q) begin
          // keep the reset display the button just picked
        end else if (fw_upgrade_i) begin
          show_d = trigger_pkg::SHOW_FW_UPGRADE;
        end else if (drv_upgrade_i) begin
          show_d = trigger_pkg::SHOW_DRV_UPGRADE;
        end else if (host_connected_i) begin
          show_d = trigger_pkg::SHOW_CONNECTED;
        end else begin
          show_d = trigger_pkg::SHOW_BROADCAST;
        end
      end
    endcase
    led_d = '0;
    case (show_q)
      trigger_pkg::SHOW_BROADCAST:   led_d.blue = blink_phase;
      trigger_pkg::SHOW_CONNECTED:   led_d.blue = 1'b1;
      trigger_pkg::SHOW_RESET_HOLD: begin
        led_d.red  = 1'b1;
        led_d.blue = 1'b1;
      end
      trigger_pkg::SHOW_RESET_BLINK: begin
        led_d.red  = blink_phase;
        led_d.blue = blink_phase;
      end
      trigger_pkg::SHOW_FW_UPGRADE:  led_d = '1;
      trigger_pkg::SHOW_DRV_UPGRADE: led_d.green = blink_phase;
      default:                       led_d = '0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      show_q       <= trigger_pkg::SHOW_BROADCAST;
      pin_hold_q   <= 28'h0000000;
      btn_hold_q   <= 28'h0000000;
      pin_done_q   <= 1'b0;
      btn_done_q   <= 1'b0;
      blinks_q     <= 2'h0;
      restore_q    <= 1'b0;
      self_reset_q <= 1'b0;
      led_q        <= '0;
      gp_q         <= 1'b0;
    end else begin
      show_q       <= show_d;
      pin_hold_q   <= pin_hold_d;
      btn_hold_q   <= btn_hold_d;
      pin_done_q   <= pin_done_d;
      btn_done_q   <= btn_done_d;
      blinks_q     <= blinks_d;
      restore_q    <= restore_d;
      self_reset_q <= self_reset_d;
      led_q        <= led_d;
      gp_q         <= gp_d;
    end
  end
  logic [31:0] addr_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_q <= 32'h00000000;
    end else begin
      addr_q <= `DEFAULT_NET_ADDR;
    end
  end
  assign frame_start_o      = start_q;
  assign exposure_window_o  = expo_on_q;
  assign net_addr_restore_o = restore_q;
  assign net_addr_default_o = addr_q;
  assign self_reset_o       = self_reset_q;
  assign led_o              = led_q;
  assign gp_out_o           = gp_q;
endmodule

// file: trigger_consts.svh
// timing counts and fixed values for the trigger and status led block
// assumes a 25 MHz system clock
`ifndef TRIGGER_CONSTS_SVH
`define TRIGGER_CONSTS_SVH
`define CLK_HZ               25000000
`define PULSE_MIN_US         100
`define PULSE_MAX_US         2000
`define PERIOD_MIN_MS        33
`define HOLD_LONG_S          10
`define HOLD_SHORT_S         5
`define BLINK_HALF_MS        500
`define PULSE_MIN_CYC        ((`CLK_HZ / 1000000) * `PULSE_MIN_US)
`define PULSE_MAX_CYC        ((`CLK_HZ / 1000000) * `PULSE_MAX_US)
`define PERIOD_MIN_CYC       ((`CLK_HZ / 1000) * `PERIOD_MIN_MS)
`define HOLD_LONG_CYC        (`CLK_HZ * `HOLD_LONG_S)
`define HOLD_SHORT_CYC       (`CLK_HZ * `HOLD_SHORT_S)
`define BLINK_HALF_CYC       ((`CLK_HZ / 1000) * `BLINK_HALF_MS)
`define DEFAULT_NET_ADDR     32'hc0a80165
`define RANGE_MODES          4
`endif

// file: trigger_pkg.sv
// types shared by the trigger and status led block
// constants live in trigger_consts.svh
package trigger_pkg;
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } led_rgb_s;
  typedef enum logic [2:0] {
    SHOW_BROADCAST,
    SHOW_CONNECTED,
    SHOW_RESET_HOLD,
    SHOW_RESET_BLINK,
    SHOW_OFF,
    SHOW_FW_UPGRADE,
    SHOW_DRV_UPGRADE
  } led_show_e;
endpackage

// file: level_sync.sv
// two flip-flop synchroniser for one pin input
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module level_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign level_o = sync_q;
endmodule

// file: blink_divider.sv
// free running blink phase, toggles every half period
// assumes one clock; half period given in clock cycles
`timescale 1ns/1ps
module blink_divider #(
  parameter int unsigned HALF_CYC = 12500000
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  output logic      phase_o,
  output logic      edge_o
);
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic        phase_q;
  logic        phase_d;
  logic        edge_q;
  logic        edge_d;
  always_comb begin
    cnt_d   = cnt_q + 24'h000001;
    phase_d = phase_q;
    edge_d  = 1'b0;
    if (cnt_q >= 24'(HALF_CYC - 1)) begin
      cnt_d   = 24'h000000;
      phase_d = ~phase_q;
      edge_d  = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q   <= 24'h000000;
      phase_q <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      edge_q  <= edge_d;
    end
  end
  assign phase_o = phase_q;
  assign edge_o  = edge_q;
endmodule

// file: trigger_and_status_led_asserts.sv
// port checks for the trigger and status led block
// bound to every trigger_and_status_led instance
`timescale 1ns/1ps
module trigger_and_status_led_asserts #(
  parameter int unsigned PERIOD_MIN_CYC = 40,
  parameter int unsigned HOLD_LONG_CYC  = 100
) (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  strobe_in_i,
  input wire logic                  net_address_restore_in_i,
  input wire logic                  restore_button_i,
  input wire logic                  slave_mode_i,
  input wire logic                  fw_upgrade_i,
  input wire logic                  frame_start_o,
  input wire logic                  exposure_window_o,
  input wire logic                  net_addr_restore_o,
  input wire logic [31:0]           net_addr_default_o,
  input wire logic                  self_reset_o,
  input wire trigger_pkg::led_rgb_s led_o
);
  // run lengths; 32 bits so no wrap within a run
  logic [31:0] since_q, since_d, pin_q, pin_d, btn_q, btn_d;
  always_comb begin
    since_d = frame_start_o ? 32'h0 : since_q + 32'h1;
    pin_d = net_address_restore_in_i ? pin_q + 32'h1 : 32'h0;
    btn_d = restore_button_i ? btn_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      since_q <= 32'h0;
      pin_q <= 32'h0;
      btn_q <= 32'h0;
    end else begin
      since_q <= since_d;
      pin_q <= pin_d;
      btn_q <= btn_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // 8 cycles is ample: slave_mode_i is not synchronised and clears armed at once, so starts stop one cycle later
  property p_slave_only;
    (!slave_mode_i) [*8] |-> !frame_start_o;
  endproperty
  a_slave_only: assert property (p_slave_only)
    else $error("frame start outside slave mode");
  property p_rise_cause;
    frame_start_o |-> $past(strobe_in_i, 3);
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("frame start without trigger pulse");
  property p_start_pulse;
    frame_start_o |=> !frame_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("frame start longer than one cycle");
  property p_min_period;
    frame_start_o |-> since_q >= PERIOD_MIN_CYC;
  endproperty
  a_min_period: assert property (p_min_period)
    else $error("frame starts closer than minimum period");
  property p_window_cause;
    $rose(exposure_window_o) |-> $past(frame_start_o);
  endproperty
  a_window_cause: assert property (p_window_cause)
    else $error("exposure window without frame start");
  property p_restore_held;
    net_addr_restore_o && !self_reset_o
      |-> pin_q >= HOLD_LONG_CYC || btn_q >= HOLD_LONG_CYC;
  endproperty
  a_restore_held: assert property (p_restore_held)
    else $error("address restore without long hold");
  property p_restore_pulse;
    net_addr_restore_o |=> !net_addr_restore_o;
  endproperty
  a_restore_pulse: assert property (p_restore_pulse)
    else $error("address restore longer than one cycle");
  property p_self_reset;
    self_reset_o |-> net_addr_restore_o;
  endproperty
  a_self_reset: assert property (p_self_reset)
    else $error("self reset without address restore");
  property p_default_addr;
    !$past(reset_i) |-> net_addr_default_o == 32'hc0a80165;
  endproperty
  a_default_addr: assert property (p_default_addr)
    else $error("default address wrong");
  property p_white;
    (fw_upgrade_i && !restore_button_i) [*4] |-> led_o == 3'h7;
  endproperty
  a_white: assert property (p_white)
    else $error("led not white during firmware upgrade");
endmodule
bind trigger_and_status_led trigger_and_status_led_asserts #(
  .PERIOD_MIN_CYC(PERIOD_MIN_CYC),
  .HOLD_LONG_CYC (HOLD_LONG_CYC)
) asserts_i (
  .clk_i                   (clk_i),
  .reset_i                 (reset_i),
  .strobe_in_i             (strobe_in_i),
  .net_address_restore_in_i(net_address_restore_in_i),
  .restore_button_i        (restore_button_i),
  .slave_mode_i            (slave_mode_i),
  .fw_upgrade_i            (fw_upgrade_i),
  .frame_start_o           (frame_start_o),
  .exposure_window_o       (exposure_window_o),
  .net_addr_restore_o      (net_addr_restore_o),
  .net_addr_default_o      (net_addr_default_o),
  .self_reset_o            (self_reset_o),
  .led_o                   (led_o)
);

// file: trig_source.sv
// trigger source model driving the external trigger pin
// assumes the bench calls fire from one process only
`timescale 1ns/1ps
module trig_source (
  input  wire logic clk_i,
  output logic      strobe_o
);
  // idles low between pulses, like a pulled-down line
  initial strobe_o = 1'h0;
  // width and gap in cycles, scaled with the design counts
  task automatic fire(input int width, input int gap);
    @(posedge clk_i);
    #1 strobe_o = 1'h1; // single clean edge, no bounce
    repeat (width) @(posedge clk_i);
    #1 strobe_o = 1'h0;
    repeat (gap) @(posedge clk_i);
    #1;
  endtask
endmodule

// file: tb.sv
// self-checking bench for the trigger and status led block
// counts shortened by parameters; trigger pin from trig_source
`timescale 1ns/1ps
module tb;
  localparam int PERIOD = 40;
  localparam int HOLD_L = 100;
  typedef struct {
    logic       sl;
    int         w;
    logic [1:0] rm;
    int         ns;
  } row_s;
  row_s rows[7] = '{'{1'h1, 8, 2'h0, 1}, '{1'h1, 8, 2'h1, 1},
    '{1'h1, 8, 2'h2, 1}, '{1'h1, 8, 2'h3, 1}, '{1'h0, 8, 2'h0, 0},
    '{1'h1, 2, 2'h0, 0}, '{1'h1, 60, 2'h1, 1}};
  // {fw, drv, host} and per colour on-counts over 16 cycles
  logic [2:0]  led_in[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [17:0] led_exp[6] = '{18'h8, 18'h10, 18'h200, 18'h200,
    18'h10410, 18'h10410};
  logic [23:0] expo[4] = '{24'h3, 24'h5, 24'h9, 24'h0};
  logic clk_i = 1'h0, reset_i = 1'h1, strobe, pin = 1'h0, btn = 1'h0;
  logic slave = 1'h1, host = 1'h0, fw = 1'h0, drv = 1'h0, gp = 1'h0;
  logic [1:0] rm = 2'h0;
  logic [17:0] ones;
  logic fs, ew, nr, sr, gpo;
  logic [31:0] addr;
  trigger_pkg::led_rgb_s led;
  int n_mismatch = 0, checks_done = 0;
  int n_start = 0, win = 0, n_rest = 0, n_self = 0, s, t, v;
  always #20 clk_i = ~clk_i;
  trig_source trig_source_i (.clk_i(clk_i), .strobe_o(strobe));
  trigger_and_status_led #(.PULSE_MIN_CYC(4), .PERIOD_MIN_CYC(PERIOD),
    .HOLD_SHORT_CYC(50), .HOLD_LONG_CYC(HOLD_L), .BLINK_HALF_CYC(4)
  ) trigger_and_status_led_i (
    .clk_i(clk_i), .reset_i(reset_i), .strobe_in_i(strobe),
    .net_address_restore_in_i(pin), .restore_button_i(btn),
    .slave_mode_i(slave), .range_mode_i(rm),
    .exposure_cyc_0_i(expo[0]), .exposure_cyc_1_i(expo[1]),
    .exposure_cyc_2_i(expo[2]), .exposure_cyc_3_i(expo[3]),
    .host_connected_i(host), .fw_upgrade_i(fw), .drv_upgrade_i(drv),
    .gp_out_level_i(gp), .frame_start_o(fs), .exposure_window_o(ew),
    .net_addr_restore_o(nr), .net_addr_default_o(addr),
    .self_reset_o(sr), .led_o(led), .gp_out_o(gpo));
  always @(posedge clk_i) begin
    if (fs === 1'h1) n_start++;
    if (ew === 1'h1) win++;
    if (nr === 1'h1) n_rest++;
    if (sr === 1'h1) n_self++;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    step(6);
    chk("addr_rst", addr, 32'h0);
    reset_i = 1'h0;
    step(PERIOD + 5);
    chk("addr", addr, 32'hc0a80165);
    foreach (rows[i]) begin
      slave = rows[i].sl;
      rm = rows[i].rm;
      gp = i[0];
      s = n_start;
      v = win;
      trig_source_i.fire(rows[i].w, 50);
      chk("starts", n_start - s, rows[i].ns);
      chk("window", win - v, rows[i].ns * expo[rows[i].rm]);
      chk("gp_out", gpo, i[0]);
    end
    // second edge falls inside the minimum period
    s = n_start;
    trig_source_i.fire(8, 12);
    trig_source_i.fire(8, 50);
    chk("pair", n_start - s, 1);
    // reset mid-run restarts the period count
    reset_i = 1'h1;
    step(2);
    reset_i = 1'h0;
    s = n_start;
    trig_source_i.fire(8, 50);
    trig_source_i.fire(8, 50);
    chk("after_rst", n_start - s, 1);
    s = n_rest;
    pin = 1'h1;
    step(HOLD_L + 50);
    pin = 1'h0;
    step(5);
    pin = 1'h1;
    step(HOLD_L - 40);
    pin = 1'h0;
    step(5);
    chk("pin_rest", n_rest - s, 1);
    s = n_rest;
    t = n_self;
    btn = 1'h1;
    step(30);
    btn = 1'h0;
    step(40);
    chk("btn_short", n_rest - s, 0);
    btn = 1'h1;
    step(70);
    chk("purple", led, 32'h5);
    btn = 1'h0;
    step(60);
    chk("self_rst", n_self - t, 1);
    chk("btn_rest", n_rest - s, 1);
    btn = 1'h1;
    step(HOLD_L + 20);
    chk("led_off", led, 32'h0);
    btn = 1'h0;
    step(20);
    chk("btn_long", n_rest - s, 2);
    chk("no_self", n_self - t, 1);
    foreach (led_in[i]) begin
      {fw, drv, host} = led_in[i];
      step(4);
      ones = 18'h0;
      repeat (16) begin
        @(posedge clk_i);
        ones += {5'h0, led.red, 5'h0, led.green, 5'h0, led.blue};
      end
      #1;
      chk("led", ones, led_exp[i]);
    end
    end_of_test;
  end
endmodule
